// *** setup_stage_state_select.sv ***
// Purpose: Derive effective setup control values from programmed state
// Assumes: Software programs state words over AXI4-Lite
// Notes: Per-primitive indices arrive from the clipper on aclk
//
// Function
// - Front fill forced solid during hz op
// - Back fill forced solid during hz op
// - Winding forced clockwise during hz op
// - Cull forced to back during hz op
// - Scissor enable from hz packet during op
// - Antialias takes hz scissor enable during op
// - Depth offset terms copied unchanged
// - Stipple enable copied from windower packet
// - Target independent raster when samples nonzero and no hz op
// - Hz flag ORs five clear/resolve bits
// - View transform disabled during hz op
// - Render target index zero during op
// - Depth format copied from internal packet
// - Viewport index zero during hz op
// - Viewport array holds at most sixteen
// - Element address is base plus 16n DWords
`timescale 1ns/1ps
`default_nettype none
module setup_stage_state_select
    import setup_sel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic prim_valid,
    input wire prim_index_t prim_in,
    output setup_effective_t setup_effective_signals,
    output logic prim_out_valid,
    output prim_out_t prim_out
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // Programmed state words
    // ************************************************************
    logic [31:0] raster_state_packet_r;
    logic [31:0] depth_const_r;
    logic [31:0] depth_scale_r;
    logic [31:0] depth_clamp_r;
    logic [31:0] depth_stencil_op_packet_r;
    logic [31:0] misc_state_r;
    logic [31:0] vp_base_r;

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic pkt_accept_r;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wire wr_hit_rc = aw_addr_r == OFS_RASTER_CTL;
    wire wr_hit_dc = aw_addr_r == OFS_DEPTH_CONST;
    wire wr_hit_ds = aw_addr_r == OFS_DEPTH_SCALE;
    wire wr_hit_dl = aw_addr_r == OFS_DEPTH_CLAMP;
    wire wr_hit_hz = aw_addr_r == OFS_HZ_OP;
    wire wr_hit_ms = aw_addr_r == OFS_MISC;
    wire wr_hit_vb = aw_addr_r == OFS_VP_BASE;
    wire wr_mapped = wr_hit_rc || wr_hit_dc || wr_hit_ds || wr_hit_dl ||
                     wr_hit_hz || wr_hit_ms || wr_hit_vb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= RESET_WORD;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            pkt_accept_r <= 1'b0;
        end else begin
            pkt_accept_r <= wr_fire && wr_mapped;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Shadow words; the strobe merge keeps unwritten lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raster_state_packet_r <= RESET_WORD;
            depth_const_r <= RESET_WORD;
            depth_scale_r <= RESET_WORD;
            depth_clamp_r <= RESET_WORD;
            depth_stencil_op_packet_r <= RESET_WORD;
            misc_state_r <= RESET_WORD;
            vp_base_r <= RESET_WORD;
        end else if (wr_fire) begin
            if (wr_hit_rc) begin
                raster_state_packet_r <= merge_strb(raster_state_packet_r, w_data_r, w_strb_r);
            end
            if (wr_hit_dc) begin
                depth_const_r <= merge_strb(depth_const_r, w_data_r, w_strb_r);
            end
            if (wr_hit_ds) begin
                depth_scale_r <= merge_strb(depth_scale_r, w_data_r, w_strb_r);
            end
            if (wr_hit_dl) begin
                depth_clamp_r <= merge_strb(depth_clamp_r, w_data_r, w_strb_r);
            end
            if (wr_hit_hz) begin
                depth_stencil_op_packet_r <= merge_strb(depth_stencil_op_packet_r,
                                                        w_data_r, w_strb_r);
            end
            if (wr_hit_ms) begin
                misc_state_r <= merge_strb(misc_state_r, w_data_r, w_strb_r);
            end
            // base alignment
            // Low bits dropped so a bad base cannot straddle elements
            if (wr_hit_vb) begin
                vp_base_r <= merge_strb(vp_base_r, w_data_r, w_strb_r) & ~VP_ALIGN_MASK;
            end
        end
    end

    // ************************************************************
    // Effective value selection
    // ************************************************************
    wire [31:0] rc = raster_state_packet_r;
    wire [31:0] hz = depth_stencil_op_packet_r;
    wire depth_stencil_op_active = hz[HZ_DCLR] || hz[HZ_DRES] || hz[HZ_HRES] ||
                                   hz[HZ_SCLR] || hz[HZ_SRES];
    setup_effective_t eff_nxt;

    always_comb begin
        eff_nxt.front_fill = depth_stencil_op_active ? FILL_SOLID : rc[RC_FRONT_FILL +: 2];
        eff_nxt.back_fill = depth_stencil_op_active ? FILL_SOLID : rc[RC_BACK_FILL +: 2];
        eff_nxt.winding = depth_stencil_op_active ? winding_clockwise : rc[RC_WINDING];
        eff_nxt.cull = depth_stencil_op_active ? cull_back_faces : rc[RC_CULL +: 2];
        eff_nxt.scissor_en = depth_stencil_op_active ? hz[HZ_SCISSOR] : rc[RC_SCISSOR];
        eff_nxt.aa_en = depth_stencil_op_active ? hz[HZ_SCISSOR] : rc[RC_AA];
        eff_nxt.depth_const = depth_const_r;
        eff_nxt.depth_scale = depth_scale_r;
        eff_nxt.depth_clamp = depth_clamp_r;
        eff_nxt.stipple_en = misc_state_r[MS_STIPPLE];
        eff_nxt.rt_indep_en = !depth_stencil_op_active &&
                              (rc[RC_SAMPLES +: 3] != zero_forced_raster_samples);
        eff_nxt.hz_active = depth_stencil_op_active;
        eff_nxt.view_xform_en = !depth_stencil_op_active && misc_state_r[MS_VIEW];
        eff_nxt.depth_format = misc_state_r[MS_DFMT +: 3];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_effective_signals <= '0;
        end else if (pkt_accept_r) begin
            setup_effective_signals <= eff_nxt;
        end
    end

    // ************************************************************
    // Per-primitive index path
    // ************************************************************
    wire hz_now = setup_effective_signals.hz_active;
    wire [3:0] vp_clamped = ({1'b0, prim_in.vp_index} > VP_LAST) ? VP_LAST[3:0]
                                                                  : prim_in.vp_index;
    wire [3:0] vp_sel = hz_now ? VP_INDEX_ZERO : vp_clamped;
    wire [10:0] rt_sel = hz_now ? RT_INDEX_ZERO : prim_in.rt_index;
    wire [31:0] vp_addr_sel = vp_base_r + 32'(vp_sel) * VP_STRIDE_BYTES;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prim_out_valid <= 1'b0;
            prim_out <= '0;
        end else begin
            prim_out_valid <= prim_valid;
            if (prim_valid) begin
                prim_out.rt_index <= rt_sel;
                prim_out.vp_index <= vp_sel;
                prim_out.vp_addr <= vp_addr_sel;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    wire [31:0] eff_word = {22'h000000, setup_effective_signals.rt_indep_en,
                            setup_effective_signals.view_xform_en,
                            setup_effective_signals.hz_active,
                            setup_effective_signals.aa_en,
                            setup_effective_signals.scissor_en,
                            setup_effective_signals.cull,
                            setup_effective_signals.winding,
                            setup_effective_signals.front_fill};
    logic [31:0] rd_word;
    logic rd_ok;

    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFS_RASTER_CTL: rd_word = raster_state_packet_r;
            OFS_DEPTH_CONST: rd_word = depth_const_r;
            OFS_DEPTH_SCALE: rd_word = depth_scale_r;
            OFS_DEPTH_CLAMP: rd_word = depth_clamp_r;
            OFS_HZ_OP: rd_word = depth_stencil_op_packet_r;
            OFS_MISC: rd_word = misc_state_r;
            OFS_VP_BASE: rd_word = vp_base_r;
            OFS_EFF_CTL: rd_word = eff_word;
            OFS_VP_ADDR: rd_word = prim_out.vp_addr;
            default: begin
                rd_word = RESET_WORD;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= RESET_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// *** setup_sel_pkg.sv ***
// Purpose: Shared types and constants for the setup stage state select
// Assumes: Field widths chosen as plain defaults where none are given
// Notes: Register map lives here, reached over AXI4-Lite
package setup_sel_pkg;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] FILL_SOLID = 2'h0;
    localparam logic winding_clockwise = 1'h0;
    localparam logic [1:0] cull_back_faces = 2'h2;
    localparam logic [2:0] zero_forced_raster_samples = 3'h0;
    localparam logic [10:0] RT_INDEX_ZERO = 11'h000;
    localparam logic [3:0] VP_INDEX_ZERO = 4'h0;

    // ************************************************************
    // Viewport array geometry
    // ************************************************************
    localparam int VP_COUNT = 16;
    localparam logic [4:0] VP_LAST = 5'h0f;
    localparam int VP_STRIDE_DW = 16;
    localparam logic [31:0] VP_STRIDE_BYTES = 32'h0000_0040;
    localparam logic [31:0] VP_ALIGN_MASK = 32'h0000_003f;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_RASTER_CTL = 8'h00;
    localparam logic [7:0] OFS_DEPTH_CONST = 8'h04;
    localparam logic [7:0] OFS_DEPTH_SCALE = 8'h08;
    localparam logic [7:0] OFS_DEPTH_CLAMP = 8'h0c;
    localparam logic [7:0] OFS_HZ_OP = 8'h10;
    localparam logic [7:0] OFS_MISC = 8'h14;
    localparam logic [7:0] OFS_VP_BASE = 8'h18;
    localparam logic [7:0] OFS_EFF_CTL = 8'h1c;
    localparam logic [7:0] OFS_VP_ADDR = 8'h20;

    // Field positions in the raster control word
    localparam int RC_FRONT_FILL = 0;
    localparam int RC_BACK_FILL = 2;
    localparam int RC_WINDING = 4;
    localparam int RC_CULL = 5;
    localparam int RC_SCISSOR = 7;
    localparam int RC_AA = 8;
    localparam int RC_SAMPLES = 9;
    // Depth-stencil operation word
    localparam int HZ_DCLR = 0;
    localparam int HZ_DRES = 1;
    localparam int HZ_HRES = 2;
    localparam int HZ_SCLR = 3;
    localparam int HZ_SRES = 4;
    localparam int HZ_SCISSOR = 5;
    // Misc word: view transform, stipple, depth format
    localparam int MS_VIEW = 0;
    localparam int MS_STIPPLE = 1;
    localparam int MS_DFMT = 4;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] front_fill;
        logic [1:0] back_fill;
        logic winding;
        logic [1:0] cull;
        logic scissor_en;
        logic aa_en;
        logic [31:0] depth_const;
        logic [31:0] depth_scale;
        logic [31:0] depth_clamp;
        logic stipple_en;
        logic rt_indep_en;
        logic hz_active;
        logic view_xform_en;
        logic [2:0] depth_format;
    } setup_effective_t;

    typedef struct packed {
        logic [10:0] rt_index;
        logic [3:0] vp_index;
    } prim_index_t;

    typedef struct packed {
        logic [10:0] rt_index;
        logic [3:0] vp_index;
        logic [31:0] vp_addr;
    } prim_out_t;

endpackage

// *** setup_sel_checker.sv ***
// Purpose: Port-level checks for the setup stage state select
// Assumes: Sync active-low reset on aclk
// Notes: Bound to the top module, watches its ports only
`timescale 1ns/1ps
`default_nettype none
module setup_sel_checker
    import setup_sel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic prim_valid,
    input wire prim_index_t prim_in,
    input wire setup_effective_t setup_effective_signals,
    input wire logic prim_out_valid,
    input wire prim_out_t prim_out
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire setup_effective_t e = setup_effective_signals;

    // Op state must hold over two cycles, a prim sees the older one
    sequence s_op_steady;
        e.hz_active && $past(e.hz_active);
    endsequence
    sequence s_bdone;
        s_axi_bvalid && s_axi_bready;
    endsequence
    property p_fill;
        e.hz_active |-> e.front_fill == FILL_SOLID && e.back_fill == FILL_SOLID;
    endproperty
    property p_orient;
        e.hz_active |-> e.winding == winding_clockwise && e.cull == cull_back_faces;
    endproperty
    property p_aa;
        e.hz_active |-> e.aa_en == e.scissor_en;
    endproperty
    property p_off;
        e.hz_active |-> !e.rt_indep_en && !e.view_xform_en;
    endproperty
    property p_zero;
        (prim_out_valid and s_op_steady) |-> prim_out.rt_index == RT_INDEX_ZERO
            && prim_out.vp_index == VP_INDEX_ZERO;
    endproperty
    property p_pass;
        prim_out_valid && !e.hz_active && !$past(e.hz_active)
            |-> prim_out.rt_index == $past(prim_in.rt_index)
            && prim_out.vp_index == $past(prim_in.vp_index);
    endproperty
    property p_align;
        prim_out_valid |-> prim_out.vp_addr[5:0] == 6'h00;
    endproperty
    property p_prim;
        prim_valid |=> prim_out_valid ##1 (prim_out_valid == $past(prim_valid));
    endproperty
    // One answer per write; a second needs a fresh address and data
    property p_bdone;
        s_bdone |=> !s_axi_bvalid;
    endproperty
    a_fill: assert property (p_fill) else $error("fill not solid in op");
    a_orient: assert property (p_orient) else $error("orientation not forced");
    a_aa: assert property (p_aa) else $error("antialias differs from scissor");
    a_off: assert property (p_off) else $error("enable left on in op");
    a_zero: assert property (p_zero) else $error("indices not zero in op");
    a_pass: assert property (p_pass) else $error("indices not passed");
    a_align: assert property (p_align) else $error("element address unaligned");
    a_prim: assert property (p_prim) else $error("primitive lost");
    a_bdone: assert property (p_bdone) else $error("write response repeated");
endmodule

bind setup_stage_state_select setup_sel_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .prim_valid(prim_valid), .prim_in(prim_in), .setup_effective_signals(setup_effective_signals),
    .prim_out_valid(prim_out_valid), .prim_out(prim_out));
`default_nettype wire

// *** clip_feed.sv ***
// Purpose: Clipper-side model issuing per-primitive indices
// Assumes: Bench raises run only while programmed state is steady
// Notes: Idle index lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module clip_feed
    import setup_sel_pkg::*;
(
    input wire logic aclk,
    input wire logic run,
    input wire logic slow,
    output logic prim_valid,
    output prim_index_t prim_in
);
    initial begin
        prim_valid = 1'b0;
        prim_in = '0;
    end
    always @(posedge aclk) begin
        if (run && !(slow && prim_valid)) begin
            prim_valid <= 1'b1;
            prim_in <= prim_index_t'($urandom);
        end else begin
            prim_valid <= 1'b0;
            prim_in <= ~prim_in;
        end
    end
endmodule
`default_nettype wire

// *** setup_stage_state_select_test.sv ***
// Purpose: Self-checking bench for the setup stage state select
// Assumes: Bench drives AXI4-Lite, clip_feed drives primitives
// Notes: Expected values come from a bench model of the state words
`timescale 1ns/1ps
`default_nettype none
module setup_stage_state_select_test;
    import setup_sel_pkg::*;
    logic aclk, aresetn, run, slow, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, op;
    logic [3:0] wstrb;
    wire logic awready, wready, bvalid, arready, rvalid, pv, pov;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire prim_index_t pin;
    wire setup_effective_t eff;
    wire prim_out_t pout;
    logic [31:0] rs [0:6];
    logic [33:0] q_bus [$];
    prim_out_t q_pr [$];
    int miscompares = 0, comparisons = 0, cyc = 0;

    setup_stage_state_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .prim_valid(pv), .prim_in(pin),
        .setup_effective_signals(eff), .prim_out_valid(pov), .prim_out(pout));
    clip_feed feed (.aclk(aclk), .run(run), .slow(slow), .prim_valid(pv), .prim_in(pin));

    // ****
    // Model and compares
    // ****
    function automatic logic hz();
        return |rs[4][4:0];
    endfunction
    function automatic setup_effective_t model();
        setup_effective_t e;
        e.front_fill = hz() ? FILL_SOLID : rs[0][1:0];
        e.back_fill = hz() ? FILL_SOLID : rs[0][3:2];
        e.winding = hz() ? winding_clockwise : rs[0][4];
        e.cull = hz() ? cull_back_faces : rs[0][6:5];
        e.scissor_en = hz() ? rs[4][5] : rs[0][7];
        e.aa_en = hz() ? rs[4][5] : rs[0][8];
        e.depth_const = rs[1];
        e.depth_scale = rs[2];
        e.depth_clamp = rs[3];
        e.stipple_en = rs[5][1];
        e.rt_indep_en = !hz() && rs[0][11:9] != zero_forced_raster_samples;
        e.hz_active = hz();
        e.view_xform_en = !hz() && rs[5][0];
        e.depth_format = rs[5][6:4];
        return e;
    endfunction
    function automatic logic [33:0] stat();
        setup_effective_t e;
        e = model();
        return {22'h0, e.rt_indep_en, e.view_xform_en, e.hz_active, e.aa_en,
            e.scissor_en, e.cull, e.winding, e.front_fill, RESP_OKAY};
    endfunction
    task automatic tally(input logic ok, input string what);
        comparisons++;
        if (!ok) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic cmp_eff(input setup_effective_t g, input setup_effective_t x);
        tally(g === x, "effective state");
    endtask
    task automatic cmp_bus(input logic [33:0] g, input logic [33:0] x);
        tally(g === x, "bus answer");
    endtask
    task automatic cmp_prim(input prim_out_t g, input prim_out_t x);
        tally(g === x, "primitive out");
    endtask

    // ****
    // Bus tasks
    // ****
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] xr);
        q_bus.push_back({32'h0, xr});
        if (xr === RESP_OKAY) begin
            for (int i = 0; i < 4; i++)
                if (s[i]) rs[a[4:2]][8*i +: 8] = d[8*i +: 8];
        end
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Response taken at the edge it first shows
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        q_bus.push_back(x);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // ****
    // Monitor
    // ****
    always @(posedge aclk) begin
        prim_index_t idx;
        if (pv) begin
            idx = hz() ? '0 : pin;
            q_pr.push_back({idx, (rs[6] & ~VP_ALIGN_MASK) + {22'h0, idx.vp_index, 6'h00}});
        end
        if ((bvalid && bready) || (rvalid && rready))
            cmp_bus(bvalid ? {32'h0, bresp} : {rdata, rresp}, q_bus.pop_front());
        if (pov)
            cmp_prim(pout, q_pr.pop_front());
    end

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Whole run is near 800 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        {awaddr, araddr, wdata, wstrb, op} = '0;
        {awvalid, wvalid, bready, arvalid, rready, run, slow, aresetn} = '0;
        foreach (rs[i]) rs[i] = '0;
        void'($urandom(44));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp_eff(eff, model());
        for (int a = 0; a < 9; a++)
            rd(8'(4 * a), {32'h0, RESP_OKAY});
        for (int k = 0; k < 12; k++) begin
            op = (k % 6 < 5) ? 32'h1 << (k % 6) : 32'h0;
            wr(OFS_RASTER_CTL, $urandom & 32'hfff, 4'hf, RESP_OKAY);
            wr(OFS_DEPTH_CONST, $urandom, 4'hf, RESP_OKAY);
            wr(OFS_DEPTH_SCALE, $urandom, 4'hf, RESP_OKAY);
            wr(OFS_DEPTH_CLAMP, $urandom, 4'($urandom), RESP_OKAY);
            wr(OFS_HZ_OP, op | ($urandom & 32'h20), 4'hf, RESP_OKAY);
            wr(OFS_MISC, $urandom & 32'h73, 4'hf, RESP_OKAY);
            wr(OFS_VP_BASE, $urandom & 32'hffffffc0, 4'hf, RESP_OKAY);
            @(posedge aclk);
            cmp_eff(eff, model());
            rd(OFS_EFF_CTL, stat());
            rd(OFS_DEPTH_CLAMP, {rs[3], RESP_OKAY});
            run <= 1'b1;
            slow <= k[0];
            repeat (24) @(posedge aclk);
            run <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        wr(8'h24, $urandom, 4'hf, RESP_SLVERR);
        wr(OFS_EFF_CTL, $urandom, 4'hf, RESP_SLVERR);
        @(posedge aclk);
        cmp_eff(eff, model());
        rd(8'h3c, {32'h0, RESP_SLVERR});
        repeat (4) @(posedge aclk);
        stop_test();
    end
endmodule
`default_nettype wire
